// *** design/afd_pkg.sv ***
`default_nettype none
package afd_pkg;
   // Register numbers
   localparam logic [3:0] SP_REG = 4'hD;
   localparam logic [3:0] PC_REG = 4'hF;
   // Encoding fields and patterns
   localparam logic [9:0]  ADC_OPC    = 10'h105;
   localparam logic [4:0]  ADDI3_OPC7 = 5'h03;
   localparam logic [1:0]  ADDI3_SUB  = 2'h2;
   localparam logic [1:0]  ADDR3_SUB  = 2'h0;
   localparam logic [4:0]  ADDI8_OPC  = 5'h06;
   localparam logic [7:0]  ADDHI_OPC  = 8'h44;
   localparam logic [4:0]  ADDSPI_OPC = 5'h15;
   localparam logic [8:0]  ADDSP7_OPC = 9'h160;
   localparam logic [7:0]  HINT_OPC   = 8'hBF;
   localparam logic [4:0]  WIDE_PFX0  = 5'h1D;
   localparam logic [4:0]  WIDE_PFX1  = 5'h1E;
   localparam logic [4:0]  WIDE_PFX2  = 5'h1F;
   // Reset values
   localparam logic [31:0] REG_RST    = 32'h0000_0000;
   localparam logic [3:0]  FLAGS_RST  = 4'h0;

   typedef enum logic [3:0] {
      AFD_NONE, AFD_ADC, AFD_ADDI3, AFD_ADDI8, AFD_ADDR3, AFD_ADDHI,
      AFD_ADDSPR, AFD_ADDSPI, AFD_ADDSP7, AFD_HINT, AFD_WIDE
   } afd_op_t;

   // Condition flags word
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } afd_flags_t;

   // Decoded instruction
   typedef struct packed {
      afd_op_t     op;
      logic [3:0]  rd;
      logic [3:0]  first_operand_reg;
      logic [3:0]  second_operand_reg;
      logic [31:0] imm;
      logic        setflags;
      logic        use_imm;
      logic        cin_flag;
   } afd_dec_t;
endpackage : afd_pkg
`default_nettype wire

// *** design/afd_decoder.sv ***
`default_nettype none
module afd_decoder
(
   input  wire logic [15:0]       i_insn,
   input  wire logic              i_in_cond_block,
   output var afd_pkg::afd_dec_t  o_dec
);
   // ************************************
   // Field extraction per encoding
   // ************************************
   logic [2:0] tiny_constant;
   logic [7:0] byte_constant;
   logic [6:0] seven_bit_constant;
   logic       dest_high_bit;
   logic [3:0] hi_dest;
   assign tiny_constant      = i_insn[8:6];
   assign byte_constant      = i_insn[7:0];
   assign seven_bit_constant = i_insn[6:0];
   assign dest_high_bit      = i_insn[7];
   assign hi_dest            = {dest_high_bit, i_insn[2:0]};

   always_comb
   begin
      o_dec          = '0;
      o_dec.op       = afd_pkg::AFD_NONE;
      // No conditional block exists, so flag forms always set flags
      o_dec.setflags = ~i_in_cond_block;
      if (i_insn[15:6] == afd_pkg::ADC_OPC)
      begin
         o_dec.op       = afd_pkg::AFD_ADC;
         o_dec.rd       = {1'b0, i_insn[2:0]};
         o_dec.first_operand_reg  = {1'b0, i_insn[2:0]};
         o_dec.second_operand_reg = {1'b0, i_insn[5:3]};
         o_dec.cin_flag = 1'b1;
      end
      else if (i_insn[15:11] == afd_pkg::ADDI3_OPC7 && i_insn[10:9] == afd_pkg::ADDI3_SUB)
      begin
         o_dec.op      = afd_pkg::AFD_ADDI3;
         o_dec.rd      = {1'b0, i_insn[2:0]};
         o_dec.first_operand_reg = {1'b0, i_insn[5:3]};
         o_dec.imm     = {29'h0, tiny_constant};
         o_dec.use_imm = 1'b1;
      end
      else if (i_insn[15:11] == afd_pkg::ADDI3_OPC7 && i_insn[10:9] == afd_pkg::ADDR3_SUB)
      begin
         o_dec.op = afd_pkg::AFD_ADDR3;
         o_dec.rd = {1'b0, i_insn[2:0]};
         o_dec.first_operand_reg  = {1'b0, i_insn[5:3]};
         o_dec.second_operand_reg = {1'b0, i_insn[8:6]};
      end
      else if (i_insn[15:11] == afd_pkg::ADDI8_OPC)
      begin
         o_dec.op      = afd_pkg::AFD_ADDI8;
         o_dec.rd      = {1'b0, i_insn[10:8]};
         o_dec.first_operand_reg = {1'b0, i_insn[10:8]};
         o_dec.imm     = {24'h0, byte_constant};
         o_dec.use_imm = 1'b1;
      end
      else if (i_insn[15:8] == afd_pkg::ADDHI_OPC)
      begin
         o_dec.setflags = 1'b0;
         o_dec.rd       = hi_dest;
         o_dec.first_operand_reg  = hi_dest;
         o_dec.second_operand_reg = i_insn[6:3];
         // Either operand naming the stack pointer redirects the form
         if (hi_dest == afd_pkg::SP_REG || i_insn[6:3] == afd_pkg::SP_REG)
         begin
            o_dec.op = afd_pkg::AFD_ADDSPR;
            o_dec.first_operand_reg  = afd_pkg::SP_REG;
            o_dec.second_operand_reg = (hi_dest == afd_pkg::SP_REG) ? i_insn[6:3] : hi_dest;
         end
         else
         begin
            o_dec.op = afd_pkg::AFD_ADDHI;
         end
      end
      else if (i_insn[15:11] == afd_pkg::ADDSPI_OPC)
      begin
         o_dec.op       = afd_pkg::AFD_ADDSPI;
         o_dec.setflags = 1'b0;
         o_dec.rd       = {1'b0, i_insn[10:8]};
         o_dec.first_operand_reg = afd_pkg::SP_REG;
         o_dec.imm      = {22'h0, byte_constant, 2'b00};
         o_dec.use_imm  = 1'b1;
      end
      else if (i_insn[15:7] == afd_pkg::ADDSP7_OPC)
      begin
         o_dec.op       = afd_pkg::AFD_ADDSP7;
         o_dec.setflags = 1'b0;
         o_dec.rd       = afd_pkg::SP_REG;
         o_dec.first_operand_reg = afd_pkg::SP_REG;
         o_dec.imm      = {23'h0, seven_bit_constant, 2'b00};
         o_dec.use_imm  = 1'b1;
      end
      else if (i_insn[15:8] == afd_pkg::HINT_OPC && i_insn[3:0] == 4'h0)
      begin
         o_dec.op       = afd_pkg::AFD_HINT;
         o_dec.setflags = 1'b0;
      end
      else if (i_insn[15:11] == afd_pkg::WIDE_PFX0 || i_insn[15:11] == afd_pkg::WIDE_PFX1 ||
               i_insn[15:11] == afd_pkg::WIDE_PFX2)
      begin
         // Wide first halves, wide hints included, are not accepted here
         o_dec.op       = afd_pkg::AFD_WIDE;
         o_dec.setflags = 1'b0;
      end
      else
      begin
         o_dec.setflags = 1'b0;
      end
   end
endmodule : afd_decoder
`default_nettype wire

// *** design/afd_core.sv ***
`default_nettype none
// Overview of operation
// - Address is base plus or minus offset
// - Offset is tiny, byte constant, or register
// - No exclusive access logic exists
// - Only narrow hints accepted, wide rejected
// - Failed condition changes no state
// - Add-carry sums both registers plus carry
// - Low bits name destination, next three source
// - Flags take sign, zero, carry, overflow
// - Never in conditional block; flag forms always update
// - Immediates zero-extended, 0-7 or 0-255
// - Add immediate uses carry-in zero, sets flags
// - Three-register form flags, high form not
// - Stack pointer operand redirects high form
// - SP plus byte constant times four
// - SP adjust by seven-bit constant times four
module afd_core
(
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_insn_valid,
   input  wire logic [15:0]         i_insn,
   input  wire logic                i_cond_check,
   input  wire logic                i_mem_valid,
   input  wire logic [3:0]          i_mem_base,
   input  wire logic [3:0]          i_mem_index,
   input  wire logic [7:0]          i_mem_imm,
   input  wire logic                i_mem_use_reg,
   input  wire logic                i_mem_subtract,
   output logic                     o_done,
   output logic                     o_undefined,
   output logic                     o_hint,
   output logic [31:0]              o_result,
   output var afd_pkg::afd_flags_t  o_status_flags_word,
   output logic                     o_mem_addr_valid,
   output logic [31:0]              o_mem_addr,
   output logic [31:0]              o_sp,
   output logic [31:0]              o_pc
);
   // ************************************
   // State
   // ************************************
   typedef struct packed {
      logic [15:0][31:0]   regs;
      afd_pkg::afd_flags_t flags;
      logic                done;
      logic                undefined;
      logic                hint;
      logic [31:0]         result;
      logic                mem_addr_valid;
      logic [31:0]         mem_addr;
   } afd_state_t;

   afd_state_t state;
   afd_state_t next_state;
   afd_pkg::afd_dec_t dec;

   // No conditional block instruction exists, so the test is constant
   afd_decoder u_decoder
   (
      .i_insn          (i_insn),
      .i_in_cond_block (1'b0),
      .o_dec           (dec)
   );

   // ************************************
   // Adder
   // ************************************
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic        cin;
   logic [32:0] sum;
   logic [31:0] res;
   logic        carry_out;
   logic        overflow;
   logic [31:0] mem_off;

   // Second operand is never shifted in this family
   always_comb
   begin
      op_a      = state.regs[dec.first_operand_reg];
      op_b      = dec.use_imm ? dec.imm : state.regs[dec.second_operand_reg];
      cin       = dec.cin_flag ? state.flags.c : 1'b0;
      sum       = {1'b0, op_a} + {1'b0, op_b} + {32'h0, cin};
      res       = sum[31:0];
      carry_out = sum[32];
      overflow  = (op_a[31] == op_b[31]) && (res[31] != op_a[31]);
   end

   // Offset addressing: base never written back, no exclusive monitor
   always_comb
   begin
      mem_off = i_mem_use_reg ? state.regs[i_mem_index] : {24'h0, i_mem_imm};
   end

   // ************************************
   // Next state
   // ************************************
   // One process commits register and flags together, so the next
   // instruction always sees both updated
   always_comb
   begin
      next_state                = state;
      next_state.done           = 1'b0;
      next_state.undefined      = 1'b0;
      next_state.hint           = 1'b0;
      next_state.mem_addr_valid = 1'b0;
      if (i_mem_valid)
      begin
         next_state.mem_addr_valid = 1'b1;
         next_state.mem_addr = i_mem_subtract ? state.regs[i_mem_base] - mem_off
                                              : state.regs[i_mem_base] + mem_off;
      end
      if (i_insn_valid)
      begin
         next_state.done = 1'b1;
         case (dec.op)
            afd_pkg::AFD_HINT:
            begin
               next_state.hint = 1'b1;
            end
            afd_pkg::AFD_WIDE,
            afd_pkg::AFD_NONE:
            begin
               // Outside this family or wide: flagged, no state change
               next_state.undefined = 1'b1;
            end
            default:
            begin
               // Condition failure leaves registers and flags alone
               if (i_cond_check)
               begin
                  // PC+PC in the high form simply adds, like any other pair
                  next_state.regs[dec.rd] = res;
                  next_state.result       = res;
                  if (dec.setflags)
                  begin
                     next_state.flags.n = res[31];
                     next_state.flags.z = (res == 32'h0000_0000);
                     next_state.flags.c = carry_out;
                     next_state.flags.v = overflow;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state       <= '0;
         state.regs  <= {16{afd_pkg::REG_RST}};
         state.flags <= afd_pkg::FLAGS_RST;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ************************************
   // Outputs, straight from state
   // ************************************
   assign o_done              = state.done;
   assign o_undefined         = state.undefined;
   assign o_hint              = state.hint;
   assign o_result            = state.result;
   assign o_status_flags_word = state.flags;
   assign o_mem_addr_valid    = state.mem_addr_valid;
   assign o_mem_addr          = state.mem_addr;
   assign o_sp                = state.regs[afd_pkg::SP_REG];
   assign o_pc                = state.regs[afd_pkg::PC_REG];

   // ************************************
   // Checks
   // ************************************
   chk_fail_no_write : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && !i_cond_check) |=> (state.flags == $past(state.flags)) && (o_result == $past(o_result)))
      else $error("state changed on failed condition");

   chk_adc_sum : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADC)
      |=> o_result == $past(state.regs[dec.first_operand_reg] + state.regs[dec.second_operand_reg] +
                            {31'h0, state.flags.c}))
      else $error("add with carry sum wrong");

   chk_flag_zero : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.setflags && dec.op != afd_pkg::AFD_NONE)
      |=> (o_status_flags_word.z == (o_result == 32'h0)) && (o_status_flags_word.n == o_result[31]))
      else $error("zero or negative flag wrong");

   chk_hi_noflags : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && (dec.op == afd_pkg::AFD_ADDHI || dec.op == afd_pkg::AFD_ADDSPI))
      |=> $stable(o_status_flags_word))
      else $error("flags changed by no-flag form");

   chk_imm_cin : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDI8)
      |=> o_result == $past(state.regs[dec.first_operand_reg] + {24'h0, i_insn[7:0]}))
      else $error("add immediate wrong");

   chk_sp_adjust : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDSP7)
      |=> o_sp == $past(o_sp) + {23'h0, $past(i_insn[6:0]), 2'b00})
      else $error("stack adjust wrong");

   chk_base_kept : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_mem_valid && !i_insn_valid) |=> $stable(state.regs))
      else $error("base register altered by addressing");

   chk_wide_undef : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && (i_insn[15:11] == afd_pkg::WIDE_PFX0 || i_insn[15:11] == afd_pkg::WIDE_PFX1 ||
                        i_insn[15:11] == afd_pkg::WIDE_PFX2)) |=> o_undefined && !o_hint)
      else $error("wide encoding accepted");

   // Every taken halfword answers with one done pulse
   chk_done_pulse : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_insn_valid
      |=> o_done)
      else $error("no done pulse after instruction");

   // Idle cycles leave done low
   chk_done_idle : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !i_insn_valid
      |=> !o_done)
      else $error("done pulse without instruction");

   // Carry checked by unsigned wrap, not by the adder's own bit
   chk_flag_carry : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.setflags)
      |=> o_status_flags_word.c == ((o_result < $past(op_a)) || ($past(cin) && (o_result == $past(op_a)))))
      else $error("carry flag wrong");

   // Signed overflow: like-signed operands, result of the other sign
   chk_flag_ovf : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.setflags)
      |=> o_status_flags_word.v == (($past(op_a[31]) == $past(op_b[31])) && (o_result[31] != $past(op_a[31]))))
      else $error("overflow flag wrong");

   // Three-bit constant zero-extended onto the named source
   chk_addi3_sum : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDI3)
      |=> o_result == $past(state.regs[{1'b0, i_insn[5:3]}] + {29'h0, i_insn[8:6]}))
      else $error("tiny constant add wrong");

   // Three-register form taken straight from the encoding fields
   chk_addr3_sum : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDR3)
      |=> o_result == $past(state.regs[{1'b0, i_insn[5:3]}] + state.regs[{1'b0, i_insn[8:6]}]))
      else $error("three register add wrong");

   // Low field is both first operand and destination
   chk_adc_dest : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADC)
      |=> state.regs[$past({1'b0, i_insn[2:0]})] == o_result)
      else $error("add with carry destination wrong");

   // Byte constant scaled by four onto the stack pointer
   chk_spi_sum : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDSPI)
      |=> o_result == $past(o_sp) + {22'h0, $past(i_insn[7:0]), 2'b00})
      else $error("stack pointer plus constant wrong");

   // High form naming the stack pointer as destination adds onto it
   chk_spr_route : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && i_insn[15:8] == afd_pkg::ADDHI_OPC &&
       {i_insn[7], i_insn[2:0]} == afd_pkg::SP_REG)
      |=> o_sp == $past(o_sp + state.regs[i_insn[6:3]]))
      else $error("stack pointer redirect wrong");

   // Failed condition leaves the whole register file alone
   chk_fail_regs : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && !i_cond_check)
      |=> $stable(state.regs))
      else $error("register written on failed condition");

   // Narrow hint is accepted, never flagged undefined
   chk_hint_flag : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_insn[15:8] == afd_pkg::HINT_OPC && i_insn[3:0] == 4'h0)
      |=> o_hint && !o_undefined)
      else $error("narrow hint not accepted");

   // Every address request answers one cycle later
   chk_mem_valid : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_mem_valid
      |=> o_mem_addr_valid)
      else $error("address request not answered");

   // Constant offset zero-extended and added or subtracted
   chk_mem_imm_addr : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_mem_valid && !i_mem_use_reg)
      |=> o_mem_addr == ($past(i_mem_subtract) ? $past(state.regs[i_mem_base]) - {24'h0, $past(i_mem_imm)}
                                               : $past(state.regs[i_mem_base]) + {24'h0, $past(i_mem_imm)}))
      else $error("constant offset address wrong");

   // High form plain sum, the both-PC case included
   chk_addhi_sum : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && i_cond_check && dec.op == afd_pkg::AFD_ADDHI)
      |=> o_result == $past(state.regs[{i_insn[7], i_insn[2:0]}] + state.regs[i_insn[6:3]]))
      else $error("high register add wrong");

   // Halfwords outside the family are flagged, never taken as hints
   chk_undef_none : assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (i_insn_valid && dec.op == afd_pkg::AFD_NONE)
      |=> o_undefined && !o_hint)
      else $error("unknown encoding not flagged");
endmodule : afd_core
`default_nettype wire

// *** test/afd_fetch_model.sv ***
`default_nettype none
// Fetch stage stand-in: presents halfwords and address requests
module afd_fetch_model
(
   input  wire logic       i_core_clk,
   output var logic        o_insn_valid,
   output var logic [15:0] o_insn,
   output var logic        o_cond_check,
   output var logic        o_mem_valid,
   output var logic [3:0]  o_mem_base,
   output var logic [3:0]  o_mem_index,
   output var logic [7:0]  o_mem_imm,
   output var logic        o_mem_use_reg,
   output var logic        o_mem_subtract
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      {o_insn_valid, o_insn, o_cond_check} = 18'h0;
      {o_mem_valid, o_mem_base, o_mem_index, o_mem_imm, o_mem_use_reg, o_mem_subtract} = 19'h0;
   end
   // One halfword, held across exactly one taken edge
   task automatic issue(input logic [15:0] insn, input logic cond);
      @(posedge i_core_clk);
      #1;
      o_insn_valid = 1'b1;
      o_insn       = insn;
      o_cond_check = cond;
      @(posedge i_core_clk);
      #1;
      o_insn_valid = 1'b0;
      o_insn       = ~insn; // Stale word shows garbage, not old value
   endtask : issue
   // Offset address request; tiny form keeps upper bits zero
   task automatic mem_req(input logic [3:0] base, input logic [3:0] index, input logic [7:0] imm,
                          input logic use_reg, input logic sub);
      @(posedge i_core_clk);
      #1;
      {o_mem_valid, o_mem_base, o_mem_index, o_mem_imm} = {1'b1, base, index, imm};
      {o_mem_use_reg, o_mem_subtract} = {use_reg, sub};
      @(posedge i_core_clk);
      #1;
      o_mem_valid = 1'b0;
      o_mem_imm   = ~imm;
   endtask : mem_req
endmodule : afd_fetch_model
`default_nettype wire

// *** test/tb_afd_core.sv ***
`default_nettype none
module tb_afd_core;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] insn;
      logic        cond;
      logic [31:0] res;
      logic [3:0]  flags;
      logic [31:0] sp;
      logic        undef;
      logic        hint;
   } afd_row_t;
   // ***********************
   // Signals
   // ***********************
   logic                clk;
   logic                rst_b;
   logic                insn_valid, cond_check, mem_valid, mem_use_reg, mem_subtract;
   logic [15:0]         insn;
   logic [3:0]          mem_base, mem_index;
   logic [7:0]          mem_imm;
   logic                done, undefined, hint, mem_addr_valid;
   logic [31:0]         result, mem_addr, sp, pc;
   afd_pkg::afd_flags_t flags;
   int                  err_total;
   int                  checks;
   // Sequence-dependent: each row sees the registers left by earlier rows
   afd_row_t rows [13] = '{
      '{16'h31FF, 1'b1, 32'h0FF, 4'h0, 32'h0, 1'b0, 1'b0}, '{16'h1DCA, 1'b1, 32'h106, 4'h0, 32'h0, 1'b0, 1'b0},
      '{16'h188B, 1'b1, 32'h205, 4'h0, 32'h0, 1'b0, 1'b0}, '{16'h1C3E, 1'b1, 32'h000, 4'h4, 32'h0, 1'b0, 1'b0},
      '{16'hADFF, 1'b1, 32'h3FC, 4'h4, 32'h0, 1'b0, 1'b0}, '{16'hB07F, 1'b1, 32'h1FC, 4'h4, 32'h1FC, 1'b0, 1'b0},
      '{16'h4495, 1'b1, 32'h302, 4'h4, 32'h302, 1'b0, 1'b0}, '{16'h347F, 1'b1, 32'h07F, 4'h0, 32'h302, 1'b0, 1'b0},
      '{16'h31FF, 1'b0, 32'h07F, 4'h0, 32'h302, 1'b0, 1'b0}, '{16'hBF00, 1'b1, 32'h07F, 4'h0, 32'h302, 1'b0, 1'b1},
      '{16'hF000, 1'b1, 32'h07F, 4'h0, 32'h302, 1'b1, 1'b0}, '{16'h0000, 1'b1, 32'h07F, 4'h0, 32'h302, 1'b1, 1'b0},
      '{16'hE800, 1'b1, 32'h07F, 4'h0, 32'h302, 1'b1, 1'b0}};
   // Carry and overflow chain, run after the doubling loop
   afd_row_t carry_rows [5] = '{
      '{16'h1849, 1'b1, 32'hFE000000, 4'hA, 32'h302, 1'b0, 1'b0},
      '{16'h4140, 1'b1, 32'h00000001, 4'h0, 32'h302, 1'b0, 1'b0},
      '{16'h1924, 1'b1, 32'hFE000000, 4'h9, 32'h302, 1'b0, 1'b0},
      '{16'h4161, 1'b1, 32'hFC000000, 4'hA, 32'h302, 1'b0, 1'b0},
      '{16'h4148, 1'b1, 32'hFC000002, 4'h8, 32'h302, 1'b0, 1'b0}};
   // First add after the mid-run reset, on a cleared register file
   afd_row_t post_row = '{16'h1C4A, 1'b1, 32'h00000001, 4'h0, 32'h0, 1'b0, 1'b0};
   afd_core afd_core_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_insn_valid(insn_valid), .i_insn(insn),
      .i_cond_check(cond_check), .i_mem_valid(mem_valid), .i_mem_base(mem_base), .i_mem_index(mem_index),
      .i_mem_imm(mem_imm), .i_mem_use_reg(mem_use_reg), .i_mem_subtract(mem_subtract), .o_done(done),
      .o_undefined(undefined), .o_hint(hint), .o_result(result), .o_status_flags_word(flags),
      .o_mem_addr_valid(mem_addr_valid), .o_mem_addr(mem_addr), .o_sp(sp), .o_pc(pc));
   afd_fetch_model afd_fetch_model_inst (.i_core_clk(clk), .o_insn_valid(insn_valid), .o_insn(insn),
      .o_cond_check(cond_check), .o_mem_valid(mem_valid), .o_mem_base(mem_base), .o_mem_index(mem_index),
      .o_mem_imm(mem_imm), .o_mem_use_reg(mem_use_reg), .o_mem_subtract(mem_subtract));
   // ***********************
   // Helpers
   // ***********************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic run_row(input afd_row_t r);
      afd_fetch_model_inst.issue(r.insn, r.cond);
      check("result", result, r.res);
      check("flags", {28'h0, flags}, {28'h0, r.flags});
      check("sp", sp, r.sp);
      check("undefined", {31'h0, undefined}, {31'h0, r.undef});
      check("hint", {31'h0, hint}, {31'h0, r.hint});
      if (!(r.undef || r.hint))
         check("done", {31'h0, done}, 32'h1);
   endtask : run_row
   task automatic mem_chk(input logic [3:0] b, input logic [3:0] x, input logic [7:0] imm, input logic u,
                          input logic s, input logic [31:0] exp);
      afd_fetch_model_inst.mem_req(b, x, imm, u, s);
      check("mem_valid", {31'h0, mem_addr_valid}, 32'h1);
      check("mem_addr", mem_addr, exp);
   endtask : mem_chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // ***********************
   // Clock, watchdog, tests
   // ***********************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run is about 160 cycles; this leaves ample margin
   initial
   begin
      #20000;
      err_total++;
      wrap_up();
   end
   initial
   begin
      err_total = 0;
      checks    = 0;
      rst_b     = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      rst_b = 1'b1;
      check("rst_result", result, 32'h0);
      check("rst_sp_pc", sp | pc, 32'h0);
      check("rst_flags", {28'h0, flags}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) run_row(rows[i]);
      $display("test rows done");
      // Base register must survive every offset request
      mem_chk(4'h3, 4'h0, 8'h07, 1'b0, 1'b0, 32'h20C);
      mem_chk(4'h3, 4'h0, 8'h05, 1'b0, 1'b1, 32'h200);
      mem_chk(4'h3, 4'h0, 8'hFF, 1'b0, 1'b0, 32'h304);
      mem_chk(4'h3, 4'h2, 8'h00, 1'b1, 1'b0, 32'h30B);
      mem_chk(4'hD, 4'h2, 8'h00, 1'b1, 1'b1, 32'h1FC);
      check("sp_kept", sp, 32'h302);
      $display("test address done");
      // High-register doubling builds wide operands without touching flags
      repeat (24)
      begin
         afd_fetch_model_inst.issue(16'h4409, 1'b1);
         afd_fetch_model_inst.issue(16'h4424, 1'b1);
      end
      check("double", result, 32'h7F000000);
      check("double_flags", {28'h0, flags}, 32'h0);
      foreach (carry_rows[i]) run_row(carry_rows[i]);
      // Program counter slot written by the high form, then PC plus PC
      afd_fetch_model_inst.issue(16'h4487, 1'b1);
      check("pc", pc, 32'hFC000002);
      afd_fetch_model_inst.issue(16'h44FF, 1'b1);
      check("pc_pc", pc, 32'hF8000004);
      check("pc_flags", {28'h0, flags}, 32'h8);
      $display("test carry done");
      // Reset in mid-run clears the visible state
      @(posedge clk);
      #1;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("rst2_result", result, 32'h0);
      check("rst2_sp", sp, 32'h0);
      check("rst2_flags_pc", {28'h0, flags} | pc, 32'h0);
      rst_b = 1'b1;
      run_row(post_row);
      $display("test reset2 done");
      wrap_up();
   end
endmodule : tb_afd_core
`default_nettype wire
